// file: src/hot_swap_backup_cfg.svh
/*
 * Constants for the hot-swap and backup sequencer: register offsets, field positions,
 * reset values and code limits.
 * Assumes it is included by bare name from the sequencer module and the bench.
 */
`ifndef HOT_SWAP_BACKUP_CFG_SVH
`define HOT_SWAP_BACKUP_CFG_SVH

// ==========================================================
// Register offsets (plain port, 8-bit address)
// ==========================================================
`define HSB_ADDR_CTRL 8'h00
`define HSB_ADDR_CHG_REF 8'h01
`define HSB_ADDR_STATUS 8'h02

// ==========================================================
// Control register fields
// ==========================================================
`define HSB_CTRL_INHIBIT_BIT 0
`define HSB_CTRL_BOOST_OFF_BIT 1

// ==========================================================
// Status register fields
// ==========================================================
`define HSB_ST_INPUT_GOOD_BIT 0
`define HSB_ST_CONNECTED_BIT 1
`define HSB_ST_FAULT_BIT 2
`define HSB_ST_SWITCHER_OK_BIT 3
`define HSB_ST_CHARGE_EN_BIT 4
`define HSB_ST_BOOST_EN_BIT 5
`define HSB_ST_DIODE_ON_BIT 6
`define HSB_ST_OVLO_BIT 7

// ==========================================================
// Reset values and code limits
// ==========================================================
`define HSB_CHG_REF_RESET 4'hA
`define HSB_CHG_REF_FULL 4'hF

`endif

// file: src/hot_swap_backup_pkg.sv
/*
 * Types for the hot-swap and backup sequencer.
 * Assumes the constants header sits beside it in src/.
 */
package hot_swap_backup_pkg;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_GATE_LOW = 2'b00, // Gate held by strong pull-down
		ST_SOFT_START = 2'b01, // Soft-start source charging
		ST_RAMP = 2'b10, // Gate pull-up, limits active
		ST_CONNECTED = 2'b11 // Input joined to output
	} seq_state_t;

	// Comparator levels from the analog power stage
	typedef struct packed {
		logic supply_qualified; // Internal supply above 3.3V
		logic input_low_compare; // Input-low sense above 1.2V
		logic input_high_compare_ok; // Input-high sense below 1.17V
		logic soft_start_reached; // Soft-start node at 1.2V
		logic retry_enable_n_low; // Retry input below 200mV
		logic timer_tripped; // Breaker timer node at 1.2V
		logic timer_discharged; // Breaker timer node below 300mV
		logic near_limit; // Current within 1.66% of folded limit
		logic diode_forward; // Output 30mV below stack
		logic diode_fast_on; // Output 65mV below stack
		logic output_above_reg; // Feedback just above regulation
		logic supply_above_on; // Internal supply above 4.3V
		logic supply_below_off; // Internal supply below 4V
		logic driver_above_on; // Driver supply above 4.2V
		logic driver_below_off; // Driver supply below 3.9V
		logic margin_high; // Output 200mV above stack
		logic margin_low; // Output within 90mV of stack
		logic input_above_ovlo; // Input above 38.6V
		logic input_below_resume; // Input below 37.2V
		logic esr_test_active; // Capacitance and ESR test running
	} compare_t;

	// Drives back to the analog power stage
	typedef struct packed {
		logic gate_strong_pulldown; // Strong gate pull-down
		logic gate_pullup; // 24uA gate pull-up source
		logic soft_start_source; // 1uA soft-start source
		logic limit_active; // Current limit and breaker armed
		logic timer_source; // 400uA timer source
		logic timer_sink; // 2uA static timer load
		logic diode_drive; // Ideal diode linear drive
		logic diode_full_on; // Ideal diode full enhancement
		logic switcher_enable; // Switching controller allowed
		logic switches_off; // Both switches forced off
		logic charge_enable; // Step-down charging allowed
		logic boost_enable; // Step-up backup allowed
		logic input_good; // Input-good released high
		logic [3:0] charge_ref_code; // Charge reference code
	} drive_t;

endpackage : hot_swap_backup_pkg

// file: src/hot_swap_backup_sequencer.sv
/*
 * Hot-swap turn-on sequencer with fault handling, retry gating, input-good,
 * ideal diode and step-up handover, switcher lockouts, charge hysteresis and
 * the charge reference code register.
 * Assumes comparator levels arrive synchronous to clk_sys_i and a plain
 * register port with one-cycle strobes.
 */
// How it works
// - Strong gate pull-down from power-up
// - Start only after supply qualifies
// - Window in range enables soft-start source
// - Soft-start done, retry low: gate pull-up
// - Limit and breaker active during ramp
// - Window exit or timer trip faults
// - After fault, stack supplies output
// - Sense limit folds 48mV to 10mV
// - Timer source near limit, static sink
// - Retry waits for timer below 300mV
// - Software inhibit acts as fault
// - Reconnect only while retry input low
// - Input-good needs all five conditions
// - Input-good mirrored into status register
// - Diode drives at 30mV, full at 65mV
// - Diode off above regulation, boost takes over
// - Switcher lockout with supply hysteresis
// - Charge enable hysteresis, needs input-good
// - Input overvoltage forces switches off
// - Four-bit linear charge reference code
// - Reference resets to 0xA, writable
// - ESR test may raise code full scale
// - Step-up enabled while input-good low
`timescale 1ns/1ns
`include "hot_swap_backup_cfg.svh"

module hot_swap_backup_sequencer (
	input wire logic clk_sys_i, // 125 MHz system clock
	input wire logic nrst_i, // Asynchronous reset, active low
	input wire logic clk_en_i, // Freezes all state while low
	input wire hot_swap_backup_pkg::compare_t compare_i, // Comparator levels
	input wire logic [7:0] reg_addr_i, // Register address
	input wire logic [7:0] reg_wdata_i, // Register write data
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
	output hot_swap_backup_pkg::drive_t drive_o // Drives to power stage
);

	// ==========================================================
	// State and registers
	// ==========================================================
	hot_swap_backup_pkg::seq_state_t state; // Sequencer state
	hot_swap_backup_pkg::seq_state_t next_state; // Next sequencer state
	logic inhibit; // Software connect-inhibit
	logic boost_off; // Software boost disable
	logic [3:0] charge_ref; // Programmed charge reference code
	logic fault_latched; // Fault seen, waiting for timer discharge
	logic switcher_ok; // Supply lockout released
	logic ovlo; // Input overvoltage lockout
	logic charge_en; // Charging allowed
	logic input_good; // Input-good level
	logic diode_on; // Ideal diode conducting
	logic fault_now; // Any fault condition this cycle
	logic retry_ok; // Sequence may be (re)attempted

	// Fault sources: window exit, breaker trip, software inhibit
	assign fault_now = !compare_i.input_low_compare || !compare_i.input_high_compare_ok
		|| compare_i.timer_tripped || inhibit;

	// Retry gating after a fault: timer discharged and retry input low
	assign retry_ok = !fault_latched
		|| (compare_i.timer_discharged && compare_i.retry_enable_n_low);

	// ==========================================================
	// Sequencer
	// ==========================================================
	// Next-state logic; any fault drops straight back to gate low
	always_comb begin
		next_state = state;
		unique case (state)
			hot_swap_backup_pkg::ST_GATE_LOW: begin
				// Wait for supply, window and retry conditions
				if (compare_i.supply_qualified && !fault_now && retry_ok) begin
					next_state = hot_swap_backup_pkg::ST_SOFT_START;
				end
			end
			hot_swap_backup_pkg::ST_SOFT_START: begin
				if (fault_now || !compare_i.supply_qualified) begin
					next_state = hot_swap_backup_pkg::ST_GATE_LOW;
				end else if (compare_i.soft_start_reached && compare_i.retry_enable_n_low) begin
					next_state = hot_swap_backup_pkg::ST_RAMP;
				end
			end
			hot_swap_backup_pkg::ST_RAMP: begin
				if (fault_now) begin
					next_state = hot_swap_backup_pkg::ST_GATE_LOW;
				end else if (!compare_i.near_limit) begin
					// Ramp ends once current drops out of the limit band
					next_state = hot_swap_backup_pkg::ST_CONNECTED;
				end
			end
			hot_swap_backup_pkg::ST_CONNECTED: begin
				if (fault_now) begin
					next_state = hot_swap_backup_pkg::ST_GATE_LOW;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= hot_swap_backup_pkg::ST_GATE_LOW;
		end else if (clk_en_i) begin
			state <= next_state;
		end
	end

	// Fault memory; cleared only once retry is allowed again
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fault_latched <= 1'b0;
		end else if (clk_en_i) begin
			if (fault_now && state != hot_swap_backup_pkg::ST_GATE_LOW) begin
				fault_latched <= 1'b1; // Set wins over clear
			end else if (fault_latched && compare_i.timer_discharged
				&& compare_i.retry_enable_n_low) begin
				fault_latched <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Lockouts and hysteresis
	// ==========================================================
	// Switcher supply lockout: on above both rising levels, off below either
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			switcher_ok <= 1'b0;
		end else if (clk_en_i) begin
			if (compare_i.supply_below_off || compare_i.driver_below_off) begin
				switcher_ok <= 1'b0;
			end else if (compare_i.supply_above_on && compare_i.driver_above_on) begin
				switcher_ok <= 1'b1;
			end
		end
	end

	// Input overvoltage lockout, independent of the hot-swap path
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ovlo <= 1'b0;
		end else if (clk_en_i) begin
			if (compare_i.input_above_ovlo) begin
				ovlo <= 1'b1;
			end else if (compare_i.input_below_resume) begin
				ovlo <= 1'b0;
			end
		end
	end

	// Input-good: window, no trip, no inhibit, connection complete
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			input_good <= 1'b0;
		end else if (clk_en_i) begin
			input_good <= compare_i.input_low_compare && compare_i.input_high_compare_ok
				&& !compare_i.timer_tripped && !inhibit
				&& state == hot_swap_backup_pkg::ST_CONNECTED
				&& !fault_now;
		end
	end

	// Charge enable with 200mV on / 90mV off margins
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			charge_en <= 1'b0;
		end else if (clk_en_i) begin
			if (!input_good || compare_i.margin_low) begin
				charge_en <= 1'b0;
			end else if (compare_i.margin_high) begin
				charge_en <= 1'b1;
			end
		end
	end

	// Ideal diode: on at forward drop, off once feedback is above regulation
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			diode_on <= 1'b0;
		end else if (clk_en_i) begin
			if (compare_i.output_above_reg) begin
				diode_on <= 1'b0;
			end else if (compare_i.diode_forward || compare_i.diode_fast_on) begin
				diode_on <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Register port
	// ==========================================================
	// Control bits and charge reference code
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			inhibit <= 1'b0;
			boost_off <= 1'b0;
			charge_ref <= `HSB_CHG_REF_RESET;
		end else if (clk_en_i && reg_wr_i) begin
			if (reg_addr_i == `HSB_ADDR_CTRL) begin
				inhibit <= reg_wdata_i[`HSB_CTRL_INHIBIT_BIT];
				boost_off <= reg_wdata_i[`HSB_CTRL_BOOST_OFF_BIT];
			end
			if (reg_addr_i == `HSB_ADDR_CHG_REF) begin
				charge_ref <= reg_wdata_i[3:0];
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (clk_en_i) begin
			reg_rdata_o <= 8'h00;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					`HSB_ADDR_CTRL: begin
						reg_rdata_o <= {6'h00, boost_off, inhibit};
					end
					`HSB_ADDR_CHG_REF: begin
						reg_rdata_o <= {4'h0, charge_ref};
					end
					`HSB_ADDR_STATUS: begin
						reg_rdata_o <= {ovlo, diode_on, drive_o.boost_enable, charge_en,
							switcher_ok, fault_latched,
							state == hot_swap_backup_pkg::ST_CONNECTED,
							input_good};
					end
					default: begin
						reg_rdata_o <= 8'h00; // Unmapped reads as zero
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Drives to the power stage
	// ==========================================================
	// Gate, soft-start and timer controls follow the state
	always_comb begin
		drive_o.gate_strong_pulldown = (state == hot_swap_backup_pkg::ST_GATE_LOW)
			|| fault_now;
		drive_o.soft_start_source = (state == hot_swap_backup_pkg::ST_SOFT_START);
		drive_o.gate_pullup = (state == hot_swap_backup_pkg::ST_RAMP
			|| state == hot_swap_backup_pkg::ST_CONNECTED) && !fault_now;
		// Limit stays armed whenever the gate can be up; fold is analog
		drive_o.limit_active = drive_o.gate_pullup
			|| state == hot_swap_backup_pkg::ST_RAMP;
		drive_o.timer_source = compare_i.near_limit && drive_o.limit_active;
		drive_o.timer_sink = 1'b1;
		drive_o.diode_drive = diode_on;
		drive_o.diode_full_on = diode_on && compare_i.diode_fast_on;
		drive_o.switcher_enable = switcher_ok;
		drive_o.switches_off = ovlo || !switcher_ok;
		drive_o.charge_enable = charge_en && switcher_ok && !ovlo;
		// Backup runs from the stack whenever input-good is low and boost_off is clear
		drive_o.boost_enable = !input_good && !boost_off;
		drive_o.input_good = input_good;
		// ESR test may lift the code up to full scale
		drive_o.charge_ref_code = compare_i.esr_test_active
			? `HSB_CHG_REF_FULL : charge_ref;
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	property p_gate_low_on_fault;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		fault_now |-> drive_o.gate_strong_pulldown && !drive_o.gate_pullup;
	endproperty
	a_gate_low_on_fault: assert property (p_gate_low_on_fault)
		else $error("gate not grounded on fault");

	property p_ramp_entry;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(state == hot_swap_backup_pkg::ST_RAMP) |->
			$past(compare_i.soft_start_reached && compare_i.retry_enable_n_low);
	endproperty
	a_ramp_entry: assert property (p_ramp_entry)
		else $error("ramp entered without soft-start and retry");

	property p_input_good_cond;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		input_good |-> $past(state == hot_swap_backup_pkg::ST_CONNECTED && !inhibit);
	endproperty
	a_input_good_cond: assert property (p_input_good_cond)
		else $error("input-good high without connection");

	property p_boost_when_bad;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		!input_good && !boost_off |-> drive_o.boost_enable;
	endproperty
	a_boost_when_bad: assert property (p_boost_when_bad)
		else $error("step-up not enabled with input-good low");

	property p_charge_needs_good;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(charge_en) |-> $past(input_good && compare_i.margin_high);
	endproperty
	a_charge_needs_good: assert property (p_charge_needs_good)
		else $error("charge enabled without margin or input-good");

	property p_ovlo_off;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ovlo |-> drive_o.switches_off && !drive_o.charge_enable;
	endproperty
	a_ovlo_off: assert property (p_ovlo_off)
		else $error("switches not off in overvoltage");

	property p_ref_full_in_test;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		compare_i.esr_test_active |-> drive_o.charge_ref_code == `HSB_CHG_REF_FULL;
	endproperty
	a_ref_full_in_test: assert property (p_ref_full_in_test)
		else $error("reference not at full scale in test");

	property p_retry_waits_timer;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(state == hot_swap_backup_pkg::ST_SOFT_START) |-> $past(retry_ok);
	endproperty
	a_retry_waits_timer: assert property (p_retry_waits_timer)
		else $error("sequence restarted before timer discharged");

	property p_switcher_lockout;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(switcher_ok) |-> $past(compare_i.supply_above_on && compare_i.driver_above_on);
	endproperty
	a_switcher_lockout: assert property (p_switcher_lockout)
		else $error("switcher released below thresholds");

endmodule : hot_swap_backup_sequencer

// file: sim/analog_stage_model.sv
/*
 * Behavioural analog power stage: soft-start node, inrush current and breaker timer node.
 * Assumes the bench sets every static comparator level through env_i.
 */
`timescale 1ns/1ns

module analog_stage_model #(
	parameter int TRIP = 40, // Timer charge that trips the breaker
	parameter int LOW = 10 // Timer charge counted as discharged
) (
	input wire logic clk_sys_i, // System clock
	input wire logic nrst_i, // Reset, active low
	input wire hot_swap_backup_pkg::compare_t env_i, // Static comparator levels
	input wire logic overload_i, // Holds the load current near the limit
	input wire logic [7:0] ss_delay_i, // Soft-start charge time in cycles
	input wire hot_swap_backup_pkg::drive_t drive_i, // Drives from the sequencer
	output hot_swap_backup_pkg::compare_t compare_o // Levels seen by the sequencer
);
	logic [7:0] ss_cnt; // Soft-start node charge
	logic [1:0] inrush; // Inrush cycles left
	logic up_q; // Gate pull-up one cycle ago
	logic near; // Current within the limit band
	logic [7:0] lvl; // Timer node charge

	// ==========================================================
	// Node integrators
	// ==========================================================
	// Nodes are registered so no loop forms through the sequencer
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ss_cnt <= 8'h00;
			inrush <= 2'h0;
			up_q <= 1'b0;
			near <= 1'b0;
			lvl <= 8'h00;
		end else begin
			// Soft-start node drains once its source stops
			if (!drive_i.soft_start_source) begin
				ss_cnt <= 8'h00;
			end else if (ss_cnt != 8'hFF) begin
				ss_cnt <= ss_cnt + 8'h01;
			end
			// Charging the output draws near-limit current for three cycles
			up_q <= drive_i.gate_pullup;
			if (drive_i.gate_pullup && !up_q) begin
				inrush <= 2'h3;
			end else if (inrush != 2'h0) begin
				inrush <= inrush - 2'h1;
			end
			near <= overload_i || (drive_i.gate_pullup && inrush != 2'h0);
			// Source outweighs the static load; the load alone drains slowly
			if (drive_i.timer_source && lvl < 8'hC8) begin
				lvl <= lvl + 8'h03;
			end else if (drive_i.timer_sink && lvl != 8'h00) begin
				lvl <= lvl - 8'h01;
			end
		end
	end

	// ==========================================================
	// Comparator outputs
	// ==========================================================
	always_comb begin
		compare_o = env_i;
		compare_o.soft_start_reached = (ss_cnt != 8'h00) && (ss_cnt >= ss_delay_i);
		compare_o.near_limit = near;
		compare_o.timer_tripped = (lvl >= 8'(TRIP));
		compare_o.timer_discharged = (lvl < 8'(LOW));
	end
endmodule : analog_stage_model

// file: sim/hot_swap_backup_sequencer_bench.sv
/*
 * Self-checking bench for the hot-swap and backup sequencer.
 * Assumes the package and constants header of src/ and the stage model of sim/.
 */
`timescale 1ns/1ns
`include "hot_swap_backup_cfg.svh"

module hot_swap_backup_sequencer_bench;
	localparam int GATE_UP = 0; // Wait selector: gate pull-up
	localparam int PULLDN = 1; // Wait selector: strong pull-down
	localparam int GOOD = 2; // Wait selector: input-good
	logic clk_sys_i; // 125 MHz clock
	logic nrst_i; // Reset, active low
	logic clk_en_i; // Held high: freezing is not exercised
	hot_swap_backup_pkg::compare_t env; // Static comparator levels
	hot_swap_backup_pkg::compare_t cmp; // Levels seen by the sequencer
	hot_swap_backup_pkg::drive_t drive_o; // Sequencer drives
	logic overload; // Keeps current near the limit
	logic [7:0] reg_addr_i; // Register address
	logic [7:0] reg_wdata_i; // Write data
	logic reg_wr_i; // Write strobe
	logic reg_rd_i; // Read strobe
	logic [7:0] reg_rdata_o; // Read data
	int n_errors; // Mismatches
	int compares; // Comparisons made

	hot_swap_backup_sequencer DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
		.compare_i(cmp), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .drive_o(drive_o));
	analog_stage_model stage (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .env_i(env),
		.overload_i(overload), .ss_delay_i(8'h05), .drive_i(drive_o), .compare_o(cmp));

	// ==========================================================
	// Clock and helpers
	// ==========================================================
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	task automatic summarize();
		if (n_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	task automatic chk_b(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_b

	task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_v

	// Ends just after an edge so that edge's updates have landed
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : settle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		chk_v(reg_rdata_o & m, exp & m);
	endtask : rd

	function automatic logic pick(input int sel);
		case (sel)
			GATE_UP: return drive_o.gate_pullup;
			PULLDN: return drive_o.gate_strong_pulldown;
			default: return drive_o.input_good;
		endcase
	endfunction : pick

	// Bounded wait; running out ends the run
	task automatic wait_on(input int sel, input logic val);
		int i;
		for (i = 0; i < 300; i++) begin
			if (pick(sel) === val) begin
				return;
			end
			settle(1);
		end
		n_errors++;
		$display("Error at %0t: wait got %h expected %h", $time, pick(sel), val);
		summarize();
	endtask : wait_on

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_reset();
		settle(6);
		chk_b(drive_o.gate_strong_pulldown, 1'b1);
		chk_b(drive_o.gate_pullup, 1'b0);
		chk_b(drive_o.input_good, 1'b0);
		chk_b(drive_o.boost_enable, 1'b1);
		chk_b(drive_o.timer_sink, 1'b1);
		chk_v({4'h0, drive_o.charge_ref_code}, 8'h0A);
		repeat (6) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		rd(`HSB_ADDR_CHG_REF, 8'h0A, 8'hFF);
	endtask : t_reset

	task automatic t_power();
		settle(20);
		chk_b(drive_o.soft_start_source, 1'b0);
		@(posedge clk_sys_i);
		env.supply_qualified <= 1'b1;
		settle(2);
		chk_b(drive_o.soft_start_source, 1'b1);
		chk_b(drive_o.gate_pullup, 1'b0);
		wait_on(GATE_UP, 1'b1);
		chk_b(drive_o.limit_active, 1'b1);
		wait_on(GOOD, 1'b1);
		chk_b(drive_o.boost_enable, 1'b0);
		rd(`HSB_ADDR_STATUS, 8'h03, 8'h03);
	endtask : t_power

	task automatic t_charge();
		@(posedge clk_sys_i);
		env.margin_high <= 1'b1;
		env.supply_above_on <= 1'b1;
		env.driver_above_on <= 1'b1;
		settle(2);
		chk_b(drive_o.charge_enable, 1'b1);
		@(posedge clk_sys_i);
		env.margin_high <= 1'b0;
		settle(3);
		chk_b(drive_o.charge_enable, 1'b1);
		@(posedge clk_sys_i);
		env.margin_low <= 1'b1;
		settle(2);
		chk_b(drive_o.charge_enable, 1'b0);
		@(posedge clk_sys_i);
		env.margin_low <= 1'b0;
		env.margin_high <= 1'b1;
		settle(2);
		chk_b(drive_o.charge_enable, 1'b1);
	endtask : t_charge

	task automatic t_switch();
		int k;
		for (k = 0; k < 2; k++) begin
			@(posedge clk_sys_i);
			env.supply_above_on <= 1'b1;
			env.driver_above_on <= 1'b1;
			settle(2);
			chk_b(drive_o.switcher_enable, 1'b1);
			@(posedge clk_sys_i);
			env.supply_above_on <= 1'b0;
			env.driver_above_on <= 1'b0;
			settle(2);
			chk_b(drive_o.switcher_enable, 1'b1);
			@(posedge clk_sys_i);
			env.supply_below_off <= (k == 0);
			env.driver_below_off <= (k == 1);
			settle(2);
			chk_b(drive_o.switcher_enable, 1'b0);
			@(posedge clk_sys_i);
			env.supply_below_off <= 1'b0;
			env.driver_below_off <= 1'b0;
			settle(2);
			chk_b(drive_o.switcher_enable, 1'b0);
		end
		@(posedge clk_sys_i);
		env.input_above_ovlo <= 1'b1;
		// Switcher released, so only the overvoltage lockout holds it off
		env.supply_above_on <= 1'b1;
		env.driver_above_on <= 1'b1;
		settle(2);
		chk_b(drive_o.switches_off, 1'b1);
		chk_b(drive_o.input_good, 1'b1);
		@(posedge clk_sys_i);
		env.input_above_ovlo <= 1'b0;
		settle(2);
		chk_b(drive_o.switches_off, 1'b1);
		@(posedge clk_sys_i);
		env.input_below_resume <= 1'b1;
		settle(2);
		chk_b(drive_o.switches_off, 1'b0);
	endtask : t_switch

	task automatic t_window();
		int k;
		for (k = 0; k < 2; k++) begin
			@(posedge clk_sys_i);
			env.input_low_compare <= (k != 0);
			env.input_high_compare_ok <= (k == 0);
			#1;
			chk_b(drive_o.gate_strong_pulldown, 1'b1);
			settle(2);
			chk_b(drive_o.gate_pullup, 1'b0);
			chk_b(drive_o.input_good, 1'b0);
			chk_b(drive_o.boost_enable, 1'b1);
			chk_b(drive_o.charge_enable, 1'b0);
			rd(`HSB_ADDR_STATUS, 8'h00, 8'h03);
			@(posedge clk_sys_i);
			env.input_low_compare <= 1'b1;
			env.input_high_compare_ok <= 1'b1;
			wait_on(GOOD, 1'b1);
		end
	endtask : t_window

	task automatic t_breaker();
		@(posedge clk_sys_i);
		env.input_low_compare <= 1'b0;
		settle(2);
		@(posedge clk_sys_i);
		env.input_low_compare <= 1'b1;
		overload <= 1'b1;
		wait_on(GATE_UP, 1'b1);
		settle(2);
		chk_b(drive_o.timer_source, 1'b1);
		chk_b(drive_o.limit_active, 1'b1);
		wait_on(PULLDN, 1'b1);
		chk_b(drive_o.gate_pullup, 1'b0);
		@(posedge clk_sys_i);
		overload <= 1'b0;
		settle(15);
		chk_b(drive_o.soft_start_source, 1'b0);
		chk_b(drive_o.timer_sink, 1'b1);
		wait_on(GOOD, 1'b1);
	endtask : t_breaker

	task automatic t_inhibit();
		@(posedge clk_sys_i);
		env.retry_enable_n_low <= 1'b0;
		wr(`HSB_ADDR_CTRL, 8'h01);
		settle(2);
		chk_b(drive_o.gate_strong_pulldown, 1'b1);
		chk_b(drive_o.input_good, 1'b0);
		chk_b(drive_o.boost_enable, 1'b1);
		wr(`HSB_ADDR_CTRL, 8'h03);
		settle(2);
		chk_b(drive_o.boost_enable, 1'b0);
		@(posedge clk_sys_i);
		env.diode_forward <= 1'b1;
		settle(2);
		chk_b(drive_o.diode_drive, 1'b1);
		chk_b(drive_o.diode_full_on, 1'b0);
		@(posedge clk_sys_i);
		env.diode_fast_on <= 1'b1;
		settle(2);
		chk_b(drive_o.diode_full_on, 1'b1);
		@(posedge clk_sys_i);
		env.output_above_reg <= 1'b1;
		settle(2);
		chk_b(drive_o.diode_drive, 1'b0);
		wr(`HSB_ADDR_CTRL, 8'h00);
		settle(60);
		chk_b(drive_o.gate_pullup, 1'b0);
		chk_b(drive_o.input_good, 1'b0);
		@(posedge clk_sys_i);
		env.retry_enable_n_low <= 1'b1;
		wait_on(GOOD, 1'b1);
	endtask : t_inhibit

	task automatic t_code();
		int k;
		for (k = 0; k < 16; k++) begin
			wr(`HSB_ADDR_CHG_REF, {4'hC, k[3:0]});
			settle(1);
			chk_v({4'h0, drive_o.charge_ref_code}, {4'h0, k[3:0]});
		end
		wr(`HSB_ADDR_CHG_REF, 8'hF7);
		rd(`HSB_ADDR_CHG_REF, 8'h07, 8'hFF);
		@(posedge clk_sys_i);
		env.esr_test_active <= 1'b1;
		settle(2);
		chk_v({4'h0, drive_o.charge_ref_code}, 8'h0F);
		@(posedge clk_sys_i);
		env.esr_test_active <= 1'b0;
		settle(2);
		chk_v({4'h0, drive_o.charge_ref_code}, 8'h07);
		rd(8'h07, 8'h00, 8'hFF);
		wr(8'h07, 8'hFF);
		rd(`HSB_ADDR_CHG_REF, 8'h07, 8'hFF);
	endtask : t_code

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		n_errors = 0;
		compares = 0;
		nrst_i = 1'b0;
		clk_en_i = 1'b1;
		overload = 1'b0;
		env = '0;
		env.input_low_compare = 1'b1;
		env.input_high_compare_ok = 1'b1;
		env.retry_enable_n_low = 1'b1;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		t_reset();
		t_power();
		t_charge();
		t_switch();
		t_window();
		t_breaker();
		t_inhibit();
		t_code();
		summarize();
	end
endmodule : hot_swap_backup_sequencer_bench
